/* File: chb_charger_defs.vh */
`ifndef CHB_CHARGER_DEFS_VH
`define CHB_CHARGER_DEFS_VH

// Bus address of the charger target, seven bits.
`define CHB_I2C_ADDR 7'h6A

// Register offsets.
`define CHB_OFS_STATUS 8'h00
`define CHB_OFS_CONTROL 8'h01
`define CHB_OFS_BATT_VOLT 8'h02
`define CHB_OFS_SAFETY 8'h06
`define CHB_OFS_LED 8'h07

// Reset values.
`define CHB_RST_CONTROL 8'h70
`define CHB_RST_BATT_VOLT 8'h0A
`define CHB_RST_SAFETY 8'h40
`define CHB_RST_LED 8'h82
`define CHB_RST_STAT_EN 1'b1

// Field positions.
`define CHB_STAT_RESTART_BIT 7
`define CHB_STAT_EN_BIT 6
`define CHB_CTL_LIMIT_HI 7
`define CHB_CTL_LIMIT_LO 6
`define CHB_CTL_WEAK_HI 5
`define CHB_CTL_WEAK_LO 4
`define CHB_CTL_TAPER_BIT 3
`define CHB_CTL_CHG_OFF_BIT 2
`define CHB_CTL_HIZ_BIT 1
`define CHB_VB_HI 7
`define CHB_VB_LO 2
`define CHB_SL_CUR_HI 7
`define CHB_SL_CUR_LO 4
`define CHB_SL_VOLT_HI 3
`define CHB_SL_VOLT_LO 0
`define CHB_LED_DRV_HI 7
`define CHB_LED_DRV_LO 6
`define CHB_LED_GATE_BIT 4
`define CHB_LED_ON_HI 3
`define CHB_LED_ON_LO 2
`define CHB_LED_OFF_HI 1
`define CHB_LED_OFF_LO 0

// Writable bit masks; other positions are reserved.
`define CHB_MASK_CONTROL 8'hFE
`define CHB_MASK_BATT_VOLT 8'hFC
`define CHB_MASK_LED 8'hDF

// Regulation limit base: 4.2 V above the 3.5 V floor, in 20 mV steps.
`define CHB_VLIMIT_BASE 6'h23

// Charge progress code for active charging.
`define CHB_STATE_CHARGING 2'h1

// Blink timing: one unit is 130 ms at 200 MHz, periods are whole units.
`define CHB_LED_UNIT_CYCLES 25'h18CBA80
`define CHB_LED_ON_CONST 2'h3
`define CHB_PRESCALE_W 25

`endif

/* File: chb_charger_regs.v */
`timescale 1ns/100ps
`include "chb_charger_defs.vh"

// Contract
// - Safety limits writable only inside post-reset window.
// - Bits 7:4 hold maximum charge current code.
// - Bits 3:0 hold maximum regulation voltage code.
// - Safety limit register resets to 0x40.
// - LED bits 7:6 select indicator drive current.
// - Gating bit: lit only charging, or always.
// - LED bits 3:2 select on period.
// - LED bits 1:0 select off period.
// - Indicator_led_config register resets to 0x82.
// - Writing status bit7 pulses timer restart, self-clearing.
// - Reading status bit7 returns limit-reset pin level.
// - Status bit6 enables indicator pin, default one.
// - Status bits 5:4 report charge progress.
// - Status bits 2:0 report fault code.
// - Status resets bit6 one, bit3 zero.
// - Control bits 7:6 select input current limit.
// - Control bits 5:4 set weak battery threshold.
// - Control bit3 enables low-current charge cutoff.
// - Control bit2 set disables charging.
// - Control bit1 set selects high impedance.
// - Control register resets to 0x70.
// - Battery register bits 7:2 set regulation target.
// - Other-register write locks limits; limits cap setpoints.
// - Limits reload on short battery or pin low.
// - Early write elsewhere locks default limits.
module chb_charger_regs #(
  parameter [`CHB_PRESCALE_W-1:0] LED_UNIT_CYCLES = `CHB_LED_UNIT_CYCLES
) (
  input wire clk_in,
  input wire rst_in,
  input wire scl_in,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe_out,
  input wire safety_limit_reset_pin_in,
  input wire battery_short_in,
  input wire [1:0] charge_progress_in,
  input wire [2:0] fault_code_in,
  input wire [3:0] fast_charge_current_in,
  output reg timer_restart_out,
  output reg indicator_pin_enable_out,
  output reg [1:0] input_current_limit_out,
  output reg [1:0] weak_battery_threshold_out,
  output reg taper_cutoff_on_out,
  output reg charge_disable_out,
  output reg high_impedance_select_out,
  output reg [5:0] regulation_voltage_field_out,
  output reg [3:0] max_charge_current_field_out,
  output reg [3:0] max_regulation_voltage_field_out,
  output reg [3:0] capped_charge_current_out,
  output reg safety_locked_out,
  output reg [1:0] indicator_drive_current_out,
  output reg indicator_lit_out
);

  localparam [6:0] ST_IDLE = 7'h01;
  localparam [6:0] ST_ADDR = 7'h02;
  localparam [6:0] ST_ACK_ADDR = 7'h04;
  localparam [6:0] ST_WR = 7'h08;
  localparam [6:0] ST_ACK_WR = 7'h10;
  localparam [6:0] ST_RD = 7'h20;
  localparam [6:0] ST_ACK_RD = 7'h40;

  reg scl_s1_q, scl_s2_q, scl_s3_q;
  reg sda_s1_q, sda_s2_q, sda_s3_q;
  reg pin_s1_q, pin_s2_q;
  reg short_s1_q, short_s2_q;
  reg [6:0] state_q;
  reg [3:0] bit_cnt_q;
  reg [7:0] shift_q;
  reg [7:0] ptr_q;
  reg rw_q;
  reg first_q;
  reg nack_q;
  reg sda_oe_q;
  reg stat_en_q;
  reg [7:0] ctl_q;
  reg [7:0] vb_q;
  reg [7:0] sl_q;
  reg [7:0] led_q;
  reg locked_q;
  reg [`CHB_PRESCALE_W-1:0] presc_q;
  reg [4:0] units_q;
  reg phase_on_q;

  wire scl_rise = scl_s2_q & ~scl_s3_q;
  wire scl_fall = ~scl_s2_q & scl_s3_q;
  wire bus_start = scl_s2_q & sda_s3_q & ~sda_s2_q;
  wire bus_stop = scl_s2_q & ~sda_s3_q & sda_s2_q;
  wire byte_done = scl_fall & (bit_cnt_q == 4'h8);
  wire wr_fire = (state_q == ST_WR) & byte_done & ~first_q;
  wire limit_reload = ~pin_s2_q | short_s2_q;

  // Register read decode.
  function [7:0] rd_mux;
    input [7:0] ofs;
    begin
      case (ofs)
        `CHB_OFS_STATUS: rd_mux = {pin_s2_q, stat_en_q, charge_progress_in, 1'b0, fault_code_in};
        `CHB_OFS_CONTROL: rd_mux = ctl_q;
        `CHB_OFS_BATT_VOLT: rd_mux = vb_q;
        `CHB_OFS_SAFETY: rd_mux = sl_q;
        `CHB_OFS_LED: rd_mux = led_q;
        default: rd_mux = 8'h00;
      endcase
    end
  endfunction

  // On length of a blink, in 130 ms units.
  function [4:0] on_units;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: on_units = 5'h01;
        2'h1: on_units = 5'h02;
        default: on_units = 5'h04;
      endcase
    end
  endfunction

  // Off length of a blink, in 130 ms units.
  function [4:0] off_units;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: off_units = 5'h03;
        2'h1: off_units = 5'h06;
        2'h2: off_units = 5'h0C;
        default: off_units = 5'h18;
      endcase
    end
  endfunction

  assign sda_out = 1'b0;
  assign sda_oe_out = sda_oe_q;

  // SCL, SDA, limit-reset pin and battery short pass two flip-flops before use; other inputs are used directly.
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      scl_s3_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_s3_q <= 1'b1;
      pin_s1_q <= 1'b1;
      pin_s2_q <= 1'b1;
      short_s1_q <= 1'b0;
      short_s2_q <= 1'b0;
    end else begin
      scl_s1_q <= scl_in;
      scl_s2_q <= scl_s1_q;
      scl_s3_q <= scl_s2_q;
      sda_s1_q <= sda_in;
      sda_s2_q <= sda_s1_q;
      sda_s3_q <= sda_s2_q;
      pin_s1_q <= safety_limit_reset_pin_in;
      pin_s2_q <= pin_s1_q;
      short_s1_q <= battery_short_in;
      short_s2_q <= short_s1_q;
    end
  end

  // Bus target: address, pointer byte, then data with auto-increment.
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= ST_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q <= 8'h00;
      ptr_q <= 8'h00;
      rw_q <= 1'b0;
      first_q <= 1'b0;
      nack_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (bus_start) begin
      state_q <= ST_ADDR;
      bit_cnt_q <= 4'h0;
      sda_oe_q <= 1'b0;
    end else if (bus_stop) begin
      state_q <= ST_IDLE;
      sda_oe_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          sda_oe_q <= 1'b0;
        end
        ST_ADDR, ST_WR: begin
          if (scl_rise) begin
            shift_q <= {shift_q[6:0], sda_s2_q};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (byte_done) begin
            if (state_q == ST_WR) begin
              state_q <= ST_ACK_WR;
              sda_oe_q <= 1'b1;
              first_q <= 1'b0;
              if (first_q) begin
                ptr_q <= shift_q;
              end else begin
                ptr_q <= ptr_q + 8'h01;
              end
            end else if (shift_q[7:1] == `CHB_I2C_ADDR) begin
              state_q <= ST_ACK_ADDR;
              sda_oe_q <= 1'b1;
              rw_q <= shift_q[0];
            end else begin
              state_q <= ST_IDLE;
            end
          end
        end
        ST_ACK_ADDR: begin
          if (scl_fall) begin
            bit_cnt_q <= 4'h0;
            if (rw_q) begin
              state_q <= ST_RD;
              shift_q <= rd_mux(ptr_q);
              sda_oe_q <= ~|(rd_mux(ptr_q) & 8'h80);
              ptr_q <= ptr_q + 8'h01;
            end else begin
              state_q <= ST_WR;
              sda_oe_q <= 1'b0;
              first_q <= 1'b1;
            end
          end
        end
        ST_ACK_WR: begin
          if (scl_fall) begin
            state_q <= ST_WR;
            bit_cnt_q <= 4'h0;
            sda_oe_q <= 1'b0;
          end
        end
        ST_RD: begin
          if (scl_fall) begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
            if (bit_cnt_q == 4'h7) begin
              state_q <= ST_ACK_RD;
              sda_oe_q <= 1'b0;
            end else begin
              shift_q <= {shift_q[6:0], 1'b0};
              sda_oe_q <= ~shift_q[6];
            end
          end
        end
        ST_ACK_RD: begin
          if (scl_rise) begin
            nack_q <= sda_s2_q;
          end else if (scl_fall) begin
            if (nack_q) begin
              state_q <= ST_IDLE;
            end else begin
              state_q <= ST_RD;
              bit_cnt_q <= 4'h0;
              shift_q <= rd_mux(ptr_q);
              sda_oe_q <= ~|(rd_mux(ptr_q) & 8'h80);
              ptr_q <= ptr_q + 8'h01;
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
          sda_oe_q <= 1'b0;
        end
      endcase
    end
  end

  // Register file.
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      stat_en_q <= `CHB_RST_STAT_EN;
      ctl_q <= `CHB_RST_CONTROL;
      vb_q <= `CHB_RST_BATT_VOLT;
      led_q <= `CHB_RST_LED;
      timer_restart_out <= 1'b0;
    end else begin
      timer_restart_out <= wr_fire & (ptr_q == `CHB_OFS_STATUS) & shift_q[`CHB_STAT_RESTART_BIT];
      if (wr_fire) begin
        case (ptr_q)
          `CHB_OFS_STATUS: stat_en_q <= shift_q[`CHB_STAT_EN_BIT];
          `CHB_OFS_CONTROL: ctl_q <= shift_q & `CHB_MASK_CONTROL;
          `CHB_OFS_BATT_VOLT: vb_q <= shift_q & `CHB_MASK_BATT_VOLT;
          `CHB_OFS_LED: led_q <= shift_q & `CHB_MASK_LED;
          default: ;
        endcase
      end
    end
  end

  // Safety limits: rewritable until any other write, reloaded by pin or short.
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sl_q <= `CHB_RST_SAFETY;
      locked_q <= 1'b0;
    end else if (limit_reload) begin
      sl_q <= `CHB_RST_SAFETY;
      locked_q <= 1'b0;
    end else if (wr_fire) begin
      if (ptr_q == `CHB_OFS_SAFETY) begin
        if (!locked_q) begin
          sl_q <= shift_q;
        end
      end else begin
        locked_q <= 1'b1;
      end
    end
  end

  // Setpoint outputs, with safety limits applied as caps whether locked or not.
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      indicator_pin_enable_out <= 1'b1;
      input_current_limit_out <= 2'h1;
      weak_battery_threshold_out <= 2'h3;
      taper_cutoff_on_out <= 1'b0;
      charge_disable_out <= 1'b0;
      high_impedance_select_out <= 1'b0;
      regulation_voltage_field_out <= 6'h02;
      max_charge_current_field_out <= 4'h4;
      max_regulation_voltage_field_out <= 4'h0;
      capped_charge_current_out <= 4'h0;
      safety_locked_out <= 1'b0;
      indicator_drive_current_out <= 2'h2;
    end else begin
      indicator_pin_enable_out <= stat_en_q;
      input_current_limit_out <= ctl_q[`CHB_CTL_LIMIT_HI:`CHB_CTL_LIMIT_LO];
      weak_battery_threshold_out <= ctl_q[`CHB_CTL_WEAK_HI:`CHB_CTL_WEAK_LO];
      taper_cutoff_on_out <= ctl_q[`CHB_CTL_TAPER_BIT];
      charge_disable_out <= ctl_q[`CHB_CTL_CHG_OFF_BIT];
      high_impedance_select_out <= ctl_q[`CHB_CTL_HIZ_BIT];
      max_charge_current_field_out <= sl_q[`CHB_SL_CUR_HI:`CHB_SL_CUR_LO];
      max_regulation_voltage_field_out <= sl_q[`CHB_SL_VOLT_HI:`CHB_SL_VOLT_LO];
      safety_locked_out <= locked_q;
      indicator_drive_current_out <= led_q[`CHB_LED_DRV_HI:`CHB_LED_DRV_LO];
      if (vb_q[`CHB_VB_HI:`CHB_VB_LO] > `CHB_VLIMIT_BASE + {2'h0, sl_q[`CHB_SL_VOLT_HI:`CHB_SL_VOLT_LO]}) begin
        regulation_voltage_field_out <= `CHB_VLIMIT_BASE + {2'h0, sl_q[`CHB_SL_VOLT_HI:`CHB_SL_VOLT_LO]};
      end else begin
        regulation_voltage_field_out <= vb_q[`CHB_VB_HI:`CHB_VB_LO];
      end
      if (fast_charge_current_in > sl_q[`CHB_SL_CUR_HI:`CHB_SL_CUR_LO]) begin
        capped_charge_current_out <= sl_q[`CHB_SL_CUR_HI:`CHB_SL_CUR_LO];
      end else begin
        capped_charge_current_out <= fast_charge_current_in;
      end
    end
  end

  // Indicator blink timer and gating.
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      presc_q <= {`CHB_PRESCALE_W{1'b0}};
      units_q <= 5'h00;
      phase_on_q <= 1'b1;
      indicator_lit_out <= 1'b0;
    end else begin
      if (presc_q == LED_UNIT_CYCLES - {{(`CHB_PRESCALE_W-1){1'b0}}, 1'b1}) begin
        presc_q <= {`CHB_PRESCALE_W{1'b0}};
        if (phase_on_q && units_q + 5'h01 >= on_units(led_q[`CHB_LED_ON_HI:`CHB_LED_ON_LO])) begin
          phase_on_q <= 1'b0;
          units_q <= 5'h00;
        end else if (!phase_on_q && units_q + 5'h01 >= off_units(led_q[`CHB_LED_OFF_HI:`CHB_LED_OFF_LO])) begin
          phase_on_q <= 1'b1;
          units_q <= 5'h00;
        end else begin
          units_q <= units_q + 5'h01;
        end
      end else begin
        presc_q <= presc_q + {{(`CHB_PRESCALE_W-1){1'b0}}, 1'b1};
      end
      indicator_lit_out <= stat_en_q & (led_q[`CHB_LED_DRV_HI:`CHB_LED_DRV_LO] != 2'h0)
        & (led_q[`CHB_LED_GATE_BIT] | (charge_progress_in == `CHB_STATE_CHARGING))
        & (phase_on_q | (led_q[`CHB_LED_ON_HI:`CHB_LED_ON_LO] == `CHB_LED_ON_CONST));
    end
  end

endmodule

/* File: chb_charger_regs_monitor.sv */
`timescale 1ns/100ps
module chb_charger_regs_monitor (
  input wire clk_in,
  input wire rst_in,
  input wire scl_in,
  input wire safety_limit_reset_pin_in,
  input wire battery_short_in,
  input wire [3:0] fast_charge_current_in,
  input wire timer_restart_out,
  input wire indicator_pin_enable_out,
  input wire [1:0] input_current_limit_out,
  input wire [1:0] weak_battery_threshold_out,
  input wire [5:0] regulation_voltage_field_out,
  input wire [3:0] max_charge_current_field_out,
  input wire [3:0] max_regulation_voltage_field_out,
  input wire [3:0] capped_charge_current_out,
  input wire safety_locked_out,
  input wire [1:0] indicator_drive_current_out,
  input wire indicator_lit_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  property p_rst_limits;
    $fell(rst_in) |-> max_charge_current_field_out == 4'h4 && max_regulation_voltage_field_out == 4'h0;
  endproperty
  a_rst_limits: assert property (p_rst_limits) else $error("limits wrong after reset");
  property p_rst_ctl;
    $fell(rst_in) |-> input_current_limit_out == 2'h1 && weak_battery_threshold_out == 2'h3;
  endproperty
  a_rst_ctl: assert property (p_rst_ctl) else $error("control wrong after reset");
  property p_restart;
    timer_restart_out |-> !scl_in ##1 !timer_restart_out;
  endproperty
  a_restart: assert property (p_restart) else $error("restart pulse wrong");
  property p_lock_hold;
    safety_locked_out |=> !safety_locked_out ||
      ($stable(max_charge_current_field_out) && $stable(max_regulation_voltage_field_out));
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("locked limits changed");
  property p_reload;
    (!safety_limit_reset_pin_in || battery_short_in) [*4] |->
      ##[0:6] (!safety_locked_out && max_charge_current_field_out == 4'h4);
  endproperty
  a_reload: assert property (p_reload) else $error("limits not reloaded");
  property p_volt_cap;
    regulation_voltage_field_out <= 6'h23 + {2'h0, max_regulation_voltage_field_out};
  endproperty
  a_volt_cap: assert property (p_volt_cap) else $error("voltage above limit");
  property p_cur_cap;
    !$past(rst_in) |-> capped_charge_current_out == ($past(fast_charge_current_in) <
      max_charge_current_field_out ? $past(fast_charge_current_in) : max_charge_current_field_out);
  endproperty
  a_cur_cap: assert property (p_cur_cap) else $error("current cap wrong");
  property p_lit_gate;
    indicator_lit_out |-> indicator_pin_enable_out && indicator_drive_current_out != 2'h0;
  endproperty
  a_lit_gate: assert property (p_lit_gate) else $error("indicator lit while off");
  c_lock: cover property ($rose(safety_locked_out));
  c_restart: cover property (timer_restart_out);
  c_lit: cover property ($rose(indicator_lit_out));
endmodule

/* File: chb_charger_regs_tb.sv */
`timescale 1ns/100ps
bind chb_charger_regs chb_charger_regs_monitor i_chb_charger_regs_monitor (.*);
module chb_charger_regs_tb;
  reg clk_in = 1'b0;
  reg rst_in = 1'b1;
  reg safety_limit_reset_pin_in = 1'b1;
  reg battery_short_in = 1'b0;
  reg [1:0] charge_progress_in = 2'h0;
  reg [2:0] fault_code_in = 3'h0;
  reg [3:0] fast_charge_current_in = 4'h0;
  reg [7:0] d, sl, v, k;
  reg [7:0] pulses = 8'h00;
  reg [31:0] r;
  integer miscompares = 0, comparisons = 0, cycles = 0, seed = 32'hA7CB, n, c, on_u, off_u;
  wire scl_in, sda_low, sda_out, sda_oe_out, timer_restart_out, indicator_pin_enable_out;
  wire taper_cutoff_on_out, charge_disable_out, high_impedance_select_out, safety_locked_out, indicator_lit_out;
  wire [1:0] input_current_limit_out, weak_battery_threshold_out, indicator_drive_current_out;
  wire [5:0] regulation_voltage_field_out;
  wire [3:0] max_charge_current_field_out, max_regulation_voltage_field_out, capped_charge_current_out;
  wire sda_in = !(sda_low || sda_oe_out);
  wire [7:0] ctl_seen = {input_current_limit_out, weak_battery_threshold_out, taper_cutoff_on_out,
    charge_disable_out, high_impedance_select_out, 1'b0};
  always #2.5 clk_in = !clk_in;
  chb_charger_regs #(.LED_UNIT_CYCLES(25'h000000A)) i_chb_charger_regs (.*);
  chb_i2c_host i_chb_i2c_host (.clk_in(clk_in), .sda_in(sda_in), .scl_out(scl_in), .sda_low_out(sda_low));
  always @(posedge clk_in) pulses <= pulses + timer_restart_out;
  always @(posedge clk_in) begin
    cycles = cycles + 1;
    if (cycles == 80000) begin
      miscompares = miscompares + 1;
      print_verdict;
    end
  end
  task print_verdict;
    begin
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [7:0] o, input [7:0] x);
    i_chb_i2c_host.wr(o, x);
  endtask
  task rdc(input [7:0] o, input [7:0] exp);
    begin
      i_chb_i2c_host.rd(o, d);
      chk(d, exp);
    end
  endtask
  task tick(input integer t);
    repeat (t) @(negedge clk_in);
  endtask
  function [5:0] mn(input [5:0] a, input [5:0] b);
    mn = a < b ? a : b;
  endfunction
  initial begin
    tick(10);
    rst_in = 1'b0;
    tick(3);
    rdc(8'h00, 8'hC0);
    rdc(8'h01, 8'h70);
    rdc(8'h02, 8'h0A);
    rdc(8'h06, 8'h40);
    rdc(8'h07, 8'h82);
    rdc(8'h05, 8'h00);
    r = $random(seed);
    sl = r[7:0];
    v = r[15:8];
    wr(8'h06, ~sl);
    wr(8'h06, sl);
    rdc(8'h06, sl);
    chk({max_charge_current_field_out, max_regulation_voltage_field_out}, sl);
    wr(8'h02, v);
    wr(8'h06, ~sl);
    rdc(8'h06, sl);
    rdc(8'h02, v & 8'hFC);
    chk({2'h0, regulation_voltage_field_out}, {2'h0, mn(v[7:2], 6'h23 + {2'h0, sl[3:0]})});
    for (n = 0; n < 16; n = n + 1) begin
      fast_charge_current_in = n[3:0];
      tick(3);
      chk({4'h0, capped_charge_current_out}, {2'h0, mn({2'h0, n[3:0]}, {2'h0, sl[7:4]})});
    end
    for (n = 0; n < 8; n = n + 1) begin
      r = $random(seed);
      if (n == 0) r[7] = 1'b1;
      charge_progress_in = n[1:0];
      fault_code_in = r[10:8];
      k = pulses;
      wr(8'h00, r[7:0]);
      chk(pulses - k, {7'h0, r[7]});
      chk({7'h0, indicator_pin_enable_out}, {7'h0, r[6]});
      rdc(8'h00, {1'b1, r[6], n[1:0], 1'b0, r[10:8]});
    end
    repeat (4) begin
      r = $random(seed);
      wr(8'h01, r[7:0]);
      rdc(8'h01, r[7:0] & 8'hFE);
      chk(ctl_seen, r[7:0] & 8'hFE);
    end
    wr(8'h00, 8'h40);
    for (n = 0; n < 4; n = n + 1) begin
      wr(8'h07, {n[1:0], 6'h3F});
      rdc(8'h07, {n[1:0], 6'h1F});
      chk({indicator_drive_current_out, 5'h0, indicator_lit_out}, {n[1:0], 5'h0, n != 0});
    end
    wr(8'h07, 8'hCF);
    for (n = 0; n < 4; n = n + 1) begin
      charge_progress_in = n[1:0];
      tick(3);
      chk({7'h0, indicator_lit_out}, {7'h0, n == 1});
    end
    for (n = 0; n < 7; n = n + 1) begin
      on_u = n < 4 ? 1 : 1 << (n - 4);
      off_u = n < 4 ? 3 << n : 3;
      wr(8'h07, n < 4 ? {6'h34, n[1:0]} : {4'hD, n[1:0], 2'h0});
      tick(300);
      c = 0;
      repeat ((on_u + off_u) * 10) begin
        @(posedge clk_in);
        #1 c = c + indicator_lit_out;
      end
      chk(c[7:0], on_u[7:0] * 8'h0A);
    end
    safety_limit_reset_pin_in = 1'b0;
    tick(8);
    rdc(8'h00, {2'h1, 2'h3, 1'b0, fault_code_in});
    rdc(8'h06, 8'h40);
    safety_limit_reset_pin_in = 1'b1;
    tick(8);
    wr(8'h07, 8'h82);
    wr(8'h06, 8'h0F);
    rdc(8'h06, 8'h40);
    battery_short_in = 1'b1;
    tick(8);
    battery_short_in = 1'b0;
    tick(8);
    chk({7'h0, safety_locked_out}, 8'h00);
    wr(8'h06, 8'hF8);
    rdc(8'h06, 8'hF8);
    print_verdict;
  end
endmodule

/* File: chb_i2c_host.sv */
`timescale 1ns/100ps
`include "chb_charger_defs.vh"
module chb_i2c_host (
  input wire clk_in,
  input wire sda_in,
  output reg scl_out,
  output reg sda_low_out
);
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  task q;
    repeat (6) @(negedge clk_in);
  endtask
  task start;
    begin
      sda_low_out = 1'b0;
      q;
      scl_out = 1'b1;
      q;
      sda_low_out = 1'b1;
      q;
      scl_out = 1'b0;
      q;
    end
  endtask
  task stop;
    begin
      sda_low_out = 1'b1;
      q;
      scl_out = 1'b1;
      q;
      sda_low_out = 1'b0;
      q;
    end
  endtask
  task xfer(input [8:0] tx, output [8:0] rx);
    integer i;
    begin
      for (i = 8; i >= 0; i = i - 1) begin
        sda_low_out = !tx[i];
        q;
        scl_out = 1'b1;
        q;
        rx[i] = sda_in;
        q;
        scl_out = 1'b0;
        q;
      end
    end
  endtask
  task wr(input [7:0] ofs, input [7:0] val);
    reg [8:0] r;
    begin
      start;
      xfer({`CHB_I2C_ADDR, 2'b01}, r);
      xfer({ofs, 1'b1}, r);
      xfer({val, 1'b1}, r);
      stop;
    end
  endtask
  task rd(input [7:0] ofs, output [7:0] val);
    reg [8:0] r;
    begin
      start;
      xfer({`CHB_I2C_ADDR, 2'b01}, r);
      xfer({ofs, 1'b1}, r);
      start;
      xfer({`CHB_I2C_ADDR, 2'b11}, r);
      xfer(9'h1FF, r);
      val = r[8:1];
      stop;
    end
  endtask
endmodule
